//--- dpio_pkg.sv
// Package with register map, field layout, reset values and carrier types for the dual I/O port block
package dpio_pkg;
   localparam int unsigned ADDR_W = 6;
   localparam logic [ADDR_W-1:0] OFS_PORT_D_PINS = 6'h00;
   localparam logic [ADDR_W-1:0] OFS_PORT_D_OUTPUT_LATCH = 6'h04;
   localparam logic [ADDR_W-1:0] OFS_PORT_D_DIRECTION = 6'h08;
   localparam logic [ADDR_W-1:0] OFS_PORT_E_PINS = 6'h0C;
   localparam logic [ADDR_W-1:0] OFS_PORT_E_OUTPUT_LATCH = 6'h10;
   localparam logic [ADDR_W-1:0] OFS_PORT_E_DIRECTION = 6'h14;
   localparam logic [ADDR_W-1:0] OFS_PARALLEL_SLAVE_CONTROL = 6'h18;
   localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 6'h1C;
   localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 6'h20;
   localparam logic [7:0] DIRECTION_RESET = 8'hFF;
   localparam logic [7:0] PIN_SAMPLE_RESET = 8'h00;
   localparam logic [3:0] SLAVE_CTRL_RESET = 4'h0;
   localparam int unsigned SLAVE_CTRL_LSB = 4;
   localparam int unsigned EV_PORT_D_CHANGE = 0;
   localparam int unsigned EV_PORT_E_CHANGE = 1;
   localparam int unsigned EV_INPUT_OVERFLOW = 2;
   localparam int unsigned EV_W = 3;
   localparam logic [2:0] EV_RESET = 3'h0;
   localparam int unsigned PE_READ_STROBE_BIT = 0;
   localparam int unsigned PE_STORE_STROBE_BIT = 1;
   localparam int unsigned PE_CHIP_SELECT_BIT = 2;
   localparam int unsigned PE_CAPTURE2_BIT = 7;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Slave-port control flags, register bits 7 to 4
   typedef struct packed {
      logic input_buffer_full;
      logic output_buffer_full;
      logic input_overflow;
      logic parallel_slave_enable;
   } dpio_slave_ctrl_t;

   // Drive of one 8-pin port
   typedef struct packed {
      logic [7:0] out;
      logic [7:0] oe;
   } dpio_pin_drive_t;
endpackage : dpio_pkg

//--- dpio_port.sv
// One bidirectional I/O port: direction, output latch, pin sampling and peripheral override
`timescale 1ns/1ps
module dpio_port #(
   parameter int unsigned WIDTH = 8
) (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic [WIDTH-1:0] pin_i,
   input wire logic dir_we_i,
   input wire logic lat_we_i,
   input wire logic [WIDTH-1:0] wdata_i,
   input wire logic [WIDTH-1:0] ovr_en_i,
   input wire logic [WIDTH-1:0] ovr_oe_i,
   input wire logic [WIDTH-1:0] ovr_out_i,
   output logic [WIDTH-1:0] dir_o,
   output logic [WIDTH-1:0] lat_o,
   output logic [WIDTH-1:0] pin_q_o,
   output logic [WIDTH-1:0] pin_out_o,
   output logic [WIDTH-1:0] pin_oe_o,
   output logic change_o
);
   logic [WIDTH-1:0] dir_q;
   logic [WIDTH-1:0] lat_q;
   logic [WIDTH-1:0] pin_q;
   logic primed_q;

   if (WIDTH == 0 || WIDTH > 8) begin : g_width_check
      $error("dpio_port: WIDTH must be 1 to 8");
   end

   // Every reset sets all direction bits to input; pins with ovr_en_i set still follow ovr_oe_i
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         dir_q <= dpio_pkg::DIRECTION_RESET[WIDTH-1:0];
      end else if (dir_we_i) begin
         dir_q <= wdata_i;
      end
   end

   // Latch is left untouched by reset
   always_ff @(posedge clk_i) begin
      if (lat_we_i) begin
         lat_q <= wdata_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         pin_q <= dpio_pkg::PIN_SAMPLE_RESET[WIDTH-1:0];
      end else begin
         pin_q <= pin_i;
      end
   end

   // Peripheral override never touches the direction register
   always_comb begin
      for (int i = 0; i < WIDTH; i++) begin
         pin_oe_o[i] = ovr_en_i[i] ? ovr_oe_i[i] : ~dir_q[i];
         pin_out_o[i] = ovr_en_i[i] ? ovr_out_i[i] : lat_q[i];
      end
   end

   // Change detect waits for one real sample, so the reset value of the sample never looks like an edge
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         primed_q <= 1'b0;
      end else begin
         primed_q <= 1'b1;
      end
   end

   assign change_o = primed_q && (|((pin_q ^ pin_i) & ~pin_oe_o));
   assign dir_o = dir_q;
   assign lat_o = lat_q;
   assign pin_q_o = pin_q;
endmodule : dpio_port

//--- dpio_top.sv
// Dual 8-bit I/O port block with slave-port hooks behind an AXI4-Lite register slave
// Contract
// - Two ports, eight pins, per-pin direction/latch/port bits
// - Direction one floats the pin as input
// - Direction zero drives the latch value
// - Latch register reads back the latch
// - Slave enable makes port D data port
// - Slave mode TTL sensing, else Schmitt trigger
// - Port E pins 0-2 are slave strobes
// - Port E pin 7 shared with capture/compare
// - Every reset sets direction bits to one
// - Port and latch data not reset (the pin sample register still clears to 00 on reset)
// - Slave control flags in bits 7-4
`timescale 1ns/1ps
module dpio_top (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [7:0] port_d_pin_i,
   output logic [7:0] port_d_pin_o,
   output logic [7:0] port_d_pin_oe_o,
   input wire logic [7:0] port_e_pin_i,
   output logic [7:0] port_e_pin_o,
   output logic [7:0] port_e_pin_oe_o,
   output logic [7:0] port_d_ttl_sense_o,
   output logic [7:0] port_e_ttl_sense_o,
   output logic [7:0] slave_data_in_o,
   input wire logic [7:0] slave_data_out_i,
   input wire logic slave_data_drive_i,
   output logic read_strobe_pin_o,
   output logic store_strobe_pin_o,
   output logic chip_select_pin_o,
   input wire logic input_buffer_full_i,
   input wire logic output_buffer_full_i,
   input wire logic input_overflow_set_i,
   input wire logic capture_compare_unit2_oe_i,
   input wire logic capture_compare_unit2_out_i,
   output logic capture_compare_unit2_in_o,
   output logic irq_o
);
   localparam int unsigned AW = dpio_pkg::ADDR_W;

   // Write and read channel state
   logic aw_got_q;
   logic w_got_q;
   logic [AW-1:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic bvalid_q;
   logic [1:0] bresp_q;
   logic rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0] rresp_q;
   logic aw_hs;
   logic w_hs;
   logic wr_fire;
   logic [AW-1:0] waddr;
   logic [31:0] wdata;
   logic [3:0] wstrb;
   logic wr_byte0;
   logic ar_hs;

   // Register state
   dpio_pkg::dpio_slave_ctrl_t slave_ctrl_q;
   logic [dpio_pkg::EV_W-1:0] irq_status_q;
   logic [dpio_pkg::EV_W-1:0] irq_mask_q;
   logic [dpio_pkg::EV_W-1:0] events;

   // Port wiring
   logic [7:0] d_dir;
   logic [7:0] d_lat;
   logic [7:0] d_pins;
   logic [7:0] e_dir;
   logic [7:0] e_lat;
   logic [7:0] e_pins;
   logic d_change;
   logic e_change;
   logic [7:0] d_ovr_en;
   logic [7:0] e_ovr_en;
   logic [7:0] e_ovr_oe;
   logic [7:0] e_ovr_out;
   dpio_pkg::dpio_pin_drive_t d_drive;
   dpio_pkg::dpio_pin_drive_t e_drive;

   function automatic logic is_mapped(input logic [AW-1:0] a);
      unique case (a)
         dpio_pkg::OFS_PORT_D_PINS, dpio_pkg::OFS_PORT_D_OUTPUT_LATCH, dpio_pkg::OFS_PORT_D_DIRECTION,
         dpio_pkg::OFS_PORT_E_PINS, dpio_pkg::OFS_PORT_E_OUTPUT_LATCH, dpio_pkg::OFS_PORT_E_DIRECTION,
         dpio_pkg::OFS_PARALLEL_SLAVE_CONTROL, dpio_pkg::OFS_IRQ_STATUS, dpio_pkg::OFS_IRQ_MASK: begin
            return 1'b1;
         end
         default: begin
            return 1'b0;
         end
      endcase
   endfunction : is_mapped

   // AXI4-Lite write path: address and data taken in either order
   assign aw_hs = s_axi_awvalid && s_axi_awready;
   assign w_hs = s_axi_wvalid && s_axi_wready;
   assign s_axi_awready = !aw_got_q && !bvalid_q;
   assign s_axi_wready = !w_got_q && !bvalid_q;
   assign waddr = aw_got_q ? awaddr_q : s_axi_awaddr[AW-1:0];
   assign wdata = w_got_q ? wdata_q : s_axi_wdata;
   assign wstrb = w_got_q ? wstrb_q : s_axi_wstrb;
   assign wr_fire = (aw_got_q || aw_hs) && (w_got_q || w_hs) && !bvalid_q;
   assign wr_byte0 = wr_fire && wstrb[0];

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         aw_got_q <= 1'b0;
         awaddr_q <= '0;
      end else if (wr_fire) begin
         aw_got_q <= 1'b0;
      end else if (aw_hs) begin
         aw_got_q <= 1'b1;
         awaddr_q <= s_axi_awaddr[AW-1:0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         w_got_q <= 1'b0;
         wdata_q <= '0;
         wstrb_q <= '0;
      end else if (wr_fire) begin
         w_got_q <= 1'b0;
      end else if (w_hs) begin
         w_got_q <= 1'b1;
         wdata_q <= s_axi_wdata;
         wstrb_q <= s_axi_wstrb;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         bvalid_q <= 1'b0;
         bresp_q <= dpio_pkg::RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_q <= 1'b1;
         bresp_q <= is_mapped(waddr) ? dpio_pkg::RESP_OKAY : dpio_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_q <= 1'b0;
      end
   end

   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;

   // Slave-port control: enable is software's, the buffer flags follow the handshake logic
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         slave_ctrl_q <= dpio_pkg::SLAVE_CTRL_RESET;
      end else begin
         slave_ctrl_q.input_buffer_full <= input_buffer_full_i;
         slave_ctrl_q.output_buffer_full <= output_buffer_full_i;
         if (input_overflow_set_i) begin
            slave_ctrl_q.input_overflow <= 1'b1;
         end else if (wr_byte0 && waddr == dpio_pkg::OFS_PARALLEL_SLAVE_CONTROL) begin
            slave_ctrl_q.input_overflow <= wdata[dpio_pkg::SLAVE_CTRL_LSB+1];
         end
         if (wr_byte0 && waddr == dpio_pkg::OFS_PARALLEL_SLAVE_CONTROL) begin
            slave_ctrl_q.parallel_slave_enable <= wdata[dpio_pkg::SLAVE_CTRL_LSB];
         end
      end
   end

   // Interrupts: sticky status, write one to clear, a new event wins over the clear
   assign events[dpio_pkg::EV_PORT_D_CHANGE] = d_change;
   assign events[dpio_pkg::EV_PORT_E_CHANGE] = e_change;
   assign events[dpio_pkg::EV_INPUT_OVERFLOW] = input_overflow_set_i;

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         irq_status_q <= dpio_pkg::EV_RESET;
      end else if (wr_byte0 && waddr == dpio_pkg::OFS_IRQ_STATUS) begin
         irq_status_q <= (irq_status_q & ~wdata[dpio_pkg::EV_W-1:0]) | events;
      end else begin
         irq_status_q <= irq_status_q | events;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         irq_mask_q <= dpio_pkg::EV_RESET;
      end else if (wr_byte0 && waddr == dpio_pkg::OFS_IRQ_MASK) begin
         irq_mask_q <= wdata[dpio_pkg::EV_W-1:0];
      end
   end

   assign irq_o = |(irq_status_q & irq_mask_q);

   // AXI4-Lite read path
   assign s_axi_arready = !rvalid_q;
   assign ar_hs = s_axi_arvalid && s_axi_arready;

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         rvalid_q <= 1'b0;
         rdata_q <= '0;
         rresp_q <= dpio_pkg::RESP_OKAY;
      end else if (ar_hs) begin
         rvalid_q <= 1'b1;
         rresp_q <= is_mapped(s_axi_araddr[AW-1:0]) ? dpio_pkg::RESP_OKAY : dpio_pkg::RESP_SLVERR;
         unique case (s_axi_araddr[AW-1:0])
            dpio_pkg::OFS_PORT_D_PINS: rdata_q <= {24'h000000, d_pins};
            dpio_pkg::OFS_PORT_D_OUTPUT_LATCH: rdata_q <= {24'h000000, d_lat};
            dpio_pkg::OFS_PORT_D_DIRECTION: rdata_q <= {24'h000000, d_dir};
            dpio_pkg::OFS_PORT_E_PINS: rdata_q <= {24'h000000, e_pins};
            dpio_pkg::OFS_PORT_E_OUTPUT_LATCH: rdata_q <= {24'h000000, e_lat};
            dpio_pkg::OFS_PORT_E_DIRECTION: rdata_q <= {24'h000000, e_dir};
            dpio_pkg::OFS_PARALLEL_SLAVE_CONTROL: rdata_q <= {24'h000000, slave_ctrl_q, 4'h0};
            dpio_pkg::OFS_IRQ_STATUS: rdata_q <= {29'h00000000, irq_status_q};
            dpio_pkg::OFS_IRQ_MASK: rdata_q <= {29'h00000000, irq_mask_q};
            default: rdata_q <= 32'h00000000;
         endcase
      end else if (s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end

   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;

   // Pin sharing: slave mode takes port D and strobes, pin 7 goes to the compare output
   assign d_ovr_en = {8{slave_ctrl_q.parallel_slave_enable}};
   assign e_ovr_en = {capture_compare_unit2_oe_i, 4'h0, {3{slave_ctrl_q.parallel_slave_enable}}};
   assign e_ovr_oe = {1'b1, 7'h00};
   assign e_ovr_out = {capture_compare_unit2_out_i, 7'h00};

   dpio_port #(
      .WIDTH(8)
   ) u_port_d (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .pin_i(port_d_pin_i),
      .dir_we_i(wr_byte0 && waddr == dpio_pkg::OFS_PORT_D_DIRECTION),
      .lat_we_i(wr_byte0 && (waddr == dpio_pkg::OFS_PORT_D_OUTPUT_LATCH || waddr == dpio_pkg::OFS_PORT_D_PINS)),
      .wdata_i(wdata[7:0]),
      .ovr_en_i(d_ovr_en),
      .ovr_oe_i({8{slave_data_drive_i}}),
      .ovr_out_i(slave_data_out_i),
      .dir_o(d_dir),
      .lat_o(d_lat),
      .pin_q_o(d_pins),
      .pin_out_o(d_drive.out),
      .pin_oe_o(d_drive.oe),
      .change_o(d_change)
   );

   dpio_port #(
      .WIDTH(8)
   ) u_port_e (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .pin_i(port_e_pin_i),
      .dir_we_i(wr_byte0 && waddr == dpio_pkg::OFS_PORT_E_DIRECTION),
      .lat_we_i(wr_byte0 && (waddr == dpio_pkg::OFS_PORT_E_OUTPUT_LATCH || waddr == dpio_pkg::OFS_PORT_E_PINS)),
      .wdata_i(wdata[7:0]),
      .ovr_en_i(e_ovr_en),
      .ovr_oe_i(e_ovr_oe),
      .ovr_out_i(e_ovr_out),
      .dir_o(e_dir),
      .lat_o(e_lat),
      .pin_q_o(e_pins),
      .pin_out_o(e_drive.out),
      .pin_oe_o(e_drive.oe),
      .change_o(e_change)
   );

   assign port_d_pin_o = d_drive.out;
   assign port_d_pin_oe_o = d_drive.oe;
   assign port_e_pin_o = e_drive.out;
   assign port_e_pin_oe_o = e_drive.oe;

   // Input threshold select, one per pin, high for TTL
   assign port_d_ttl_sense_o = {8{slave_ctrl_q.parallel_slave_enable}};
   assign port_e_ttl_sense_o = {5'h00, {3{slave_ctrl_q.parallel_slave_enable}}};

   assign slave_data_in_o = d_pins;
   assign read_strobe_pin_o = e_pins[dpio_pkg::PE_READ_STROBE_BIT];
   assign store_strobe_pin_o = e_pins[dpio_pkg::PE_STORE_STROBE_BIT];
   assign chip_select_pin_o = e_pins[dpio_pkg::PE_CHIP_SELECT_BIT];
   assign capture_compare_unit2_in_o = e_pins[dpio_pkg::PE_CAPTURE2_BIT];

   // Checks
   property p_dir_input;
      @(posedge clk_i) disable iff (!reset_n_i)
      !slave_ctrl_q.parallel_slave_enable && !capture_compare_unit2_oe_i |-> ((port_e_pin_oe_o & e_dir) == 8'h00);
   endproperty
   a_dir_input: assert property (p_dir_input) else $error("input pin driven");

   property p_dir_output;
      @(posedge clk_i) disable iff (!reset_n_i)
      !slave_ctrl_q.parallel_slave_enable && d_dir == 8'h00 |-> port_d_pin_oe_o == 8'hFF && port_d_pin_o == d_lat;
   endproperty
   a_dir_output: assert property (p_dir_output) else $error("output pin not driven from latch");

   property p_latch_read;
      @(posedge clk_i) disable iff (!reset_n_i)
      ar_hs && s_axi_araddr[AW-1:0] == dpio_pkg::OFS_PORT_D_OUTPUT_LATCH |=> s_axi_rdata[7:0] == $past(d_lat);
   endproperty
   a_latch_read: assert property (p_latch_read) else $error("latch read mismatch");

   property p_slave_data;
      @(posedge clk_i) disable iff (!reset_n_i)
      slave_ctrl_q.parallel_slave_enable |-> port_d_pin_oe_o == {8{slave_data_drive_i}} && port_d_pin_o == slave_data_out_i;
   endproperty
   a_slave_data: assert property (p_slave_data) else $error("port D not under slave port");

   property p_ttl;
      @(posedge clk_i) disable iff (!reset_n_i)
      port_d_ttl_sense_o == {8{slave_ctrl_q.parallel_slave_enable}} && port_e_ttl_sense_o[7:3] == 5'h00;
   endproperty
   a_ttl: assert property (p_ttl) else $error("threshold select wrong");

   property p_strobes_in;
      @(posedge clk_i) disable iff (!reset_n_i)
      slave_ctrl_q.parallel_slave_enable |-> port_e_pin_oe_o[2:0] == 3'h0;
   endproperty
   a_strobes_in: assert property (p_strobes_in) else $error("strobe pin driven");

   property p_capture2;
      @(posedge clk_i) disable iff (!reset_n_i)
      capture_compare_unit2_oe_i |-> port_e_pin_oe_o[7] && port_e_pin_o[7] == capture_compare_unit2_out_i;
   endproperty
   a_capture2: assert property (p_capture2) else $error("compare output not on pin 7");

   property p_reset_dir;
      @(posedge clk_i)
      !reset_n_i |=> d_dir == 8'hFF && e_dir == 8'hFF && port_d_pin_oe_o == 8'h00;
   endproperty
   a_reset_dir: assert property (p_reset_dir) else $error("direction not all inputs after reset");

   property p_ctrl_low;
      @(posedge clk_i) disable iff (!reset_n_i)
      ar_hs && s_axi_araddr[AW-1:0] == dpio_pkg::OFS_PARALLEL_SLAVE_CONTROL |=> s_axi_rdata[3:0] == 4'h0;
   endproperty
   a_ctrl_low: assert property (p_ctrl_low) else $error("unimplemented control bits not zero");

   property p_pins_write;
      @(posedge clk_i) disable iff (!reset_n_i)
      wr_byte0 && waddr == dpio_pkg::OFS_PORT_E_PINS |=> e_lat == $past(wdata[7:0]);
   endproperty
   a_pins_write: assert property (p_pins_write) else $error("port write missed latch");

   c_write: cover property (@(posedge clk_i) disable iff (!reset_n_i) wr_fire ##1 s_axi_bvalid);
   c_slave_mode: cover property (@(posedge clk_i) disable iff (!reset_n_i) $rose(slave_ctrl_q.parallel_slave_enable));
   c_irq: cover property (@(posedge clk_i) disable iff (!reset_n_i) $rose(irq_o));
   c_capture2: cover property (@(posedge clk_i) disable iff (!reset_n_i) capture_compare_unit2_oe_i ##1 !capture_compare_unit2_oe_i);
endmodule : dpio_top

//--- dpio_pin_partner.sv
// Outside circuitry on one 8-pin port: resolves the pad level from device and external drivers
`timescale 1ns/1ps
module dpio_pin_partner (
   input wire logic clk_i,
   input wire logic [7:0] drv_i,
   input wire logic [7:0] oe_i,
   input wire logic [7:0] ext_en_i,
   input wire logic [7:0] ext_val_i,
   output logic [7:0] level_o
);
   // A pad nobody drives wanders: it shows the inverse of its last level
   logic [7:0] float_q = 8'h00;

   always_ff @(posedge clk_i) begin
      float_q <= ~level_o;
   end

   // External master drives every pad whose ext_en_i bit is set, only where the device floats it
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         level_o[i] = oe_i[i] ? drv_i[i] : (ext_en_i[i] ? ext_val_i[i] : float_q[i]);
      end
   end
endmodule : dpio_pin_partner

//--- dpio_top_bench.sv
// Self-checking bench for the dual I/O port block over its register bus and pins
`timescale 1ns/1ps
module dpio_top_bench;
   typedef struct packed {
      logic wr;
      logic [5:0] a;
      logic [7:0] d;
      logic [31:0] exp;
      logic [1:0] resp;
   } dpio_row_t;

   logic clk_i, reset_n_i;
   logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [7:0] port_d_pin_i, port_d_pin_o, port_d_pin_oe_o, port_e_pin_i, port_e_pin_o, port_e_pin_oe_o;
   logic [7:0] port_d_ttl_sense_o, port_e_ttl_sense_o, slave_data_in_o, slave_data_out_i;
   logic slave_data_drive_i, read_strobe_pin_o, store_strobe_pin_o, chip_select_pin_o;
   logic input_buffer_full_i, output_buffer_full_i, input_overflow_set_i;
   logic capture_compare_unit2_oe_i, capture_compare_unit2_out_i, capture_compare_unit2_in_o, irq_o;
   logic [7:0] ext_d_en, ext_d_val, ext_e_en, ext_e_val;
   logic [31:0] rd;
   logic [1:0] rs;
   int bad_count = 0;
   int total_checks = 0;
   int cycles = 0;

   dpio_top i_dut (.clk_i, .reset_n_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .port_d_pin_i, .port_d_pin_o, .port_d_pin_oe_o, .port_e_pin_i, .port_e_pin_o,
      .port_e_pin_oe_o, .port_d_ttl_sense_o, .port_e_ttl_sense_o, .slave_data_in_o, .slave_data_out_i,
      .slave_data_drive_i, .read_strobe_pin_o, .store_strobe_pin_o, .chip_select_pin_o,
      .input_buffer_full_i, .output_buffer_full_i, .input_overflow_set_i, .capture_compare_unit2_oe_i,
      .capture_compare_unit2_out_i, .capture_compare_unit2_in_o, .irq_o);

   dpio_pin_partner i_pads_d (.clk_i(clk_i), .drv_i(port_d_pin_o), .oe_i(port_d_pin_oe_o),
      .ext_en_i(ext_d_en), .ext_val_i(ext_d_val), .level_o(port_d_pin_i));
   dpio_pin_partner i_pads_e (.clk_i(clk_i), .drv_i(port_e_pin_o), .oe_i(port_e_pin_oe_o),
      .ext_en_i(ext_e_en), .ext_val_i(ext_e_val), .level_o(port_e_pin_i));

   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : tally_and_finish

   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 6000) begin
         bad_count++;
         tally_and_finish();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD at %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // Handshakes are judged on settled values half a cycle before the edge that takes them
   task automatic wr(input logic [5:0] a, input logic [7:0] d, output logic [1:0] r);
      logic aw_done;
      logic w_done;
      logic b_done;
      @(posedge clk_i);
      s_axi_awaddr <= {26'h0, a};
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      b_done = 1'b0;
      while (!b_done) begin
         @(negedge clk_i);
         aw_done = s_axi_awvalid && s_axi_awready;
         w_done = s_axi_wvalid && s_axi_wready;
         b_done = s_axi_bvalid;
         r = s_axi_bresp;
         @(posedge clk_i);
         if (aw_done) s_axi_awvalid <= 1'b0;
         if (w_done) s_axi_wvalid <= 1'b0;
      end
      s_axi_bready <= 1'b0;
   endtask : wr

   task automatic rdr(input logic [5:0] a, output logic [31:0] d, output logic [1:0] r);
      logic ar_done;
      logic r_done;
      @(posedge clk_i);
      s_axi_araddr <= {26'h0, a};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      r_done = 1'b0;
      while (!r_done) begin
         @(negedge clk_i);
         ar_done = s_axi_arvalid && s_axi_arready;
         r_done = s_axi_rvalid;
         d = s_axi_rdata;
         r = s_axi_rresp;
         @(posedge clk_i);
         if (ar_done) s_axi_arvalid <= 1'b0;
      end
      s_axi_rready <= 1'b0;
   endtask : rdr

   // Register map walk: reset values, latch readback, port write, unmapped place
   localparam dpio_row_t ROWS [16] = '{
      '{1'b0, 6'h1C, 8'h00, 32'h0000_0000, 2'h0},
      '{1'b0, 6'h08, 8'h00, 32'h0000_00FF, 2'h0}, '{1'b0, 6'h14, 8'h00, 32'h0000_00FF, 2'h0},
      '{1'b0, 6'h18, 8'h00, 32'h0000_0000, 2'h0}, '{1'b1, 6'h04, 8'hA5, 32'h0, 2'h0},
      '{1'b0, 6'h04, 8'h00, 32'h0000_00A5, 2'h0}, '{1'b1, 6'h0C, 8'h3C, 32'h0, 2'h0},
      '{1'b0, 6'h10, 8'h00, 32'h0000_003C, 2'h0}, '{1'b1, 6'h00, 8'h5A, 32'h0, 2'h0},
      '{1'b0, 6'h04, 8'h00, 32'h0000_005A, 2'h0}, '{1'b1, 6'h18, 8'h0F, 32'h0, 2'h0},
      '{1'b0, 6'h18, 8'h00, 32'h0000_0000, 2'h0}, '{1'b0, 6'h24, 8'h00, 32'h0000_0000, 2'h2},
      '{1'b1, 6'h24, 8'h11, 32'h0, 2'h2}, '{1'b0, 6'h0C, 8'h00, 32'h0000_0005, 2'h0},
      '{1'b1, 6'h08, 8'h00, 32'h0, 2'h0}};

   initial begin
      reset_n_i = 1'b0;
      {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
      s_axi_wstrb = 4'hF;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {slave_data_out_i, slave_data_drive_i, input_buffer_full_i, output_buffer_full_i} = '0;
      {input_overflow_set_i, capture_compare_unit2_oe_i, capture_compare_unit2_out_i} = '0;
      ext_d_en = 8'hFF;
      ext_d_val = 8'hC3;
      ext_e_en = 8'hFF;
      ext_e_val = 8'h05;
      repeat (6) @(posedge clk_i);
      reset_n_i <= 1'b1;
      foreach (ROWS[i]) begin
         if (ROWS[i].wr) begin
            wr(ROWS[i].a, ROWS[i].d, rs);
         end else begin
            rdr(ROWS[i].a, rd, rs);
            chk(rd, ROWS[i].exp);
         end
         chk({30'h0, rs}, {30'h0, ROWS[i].resp});
      end
      $display("test register table done");
      chk({24'h0, port_d_pin_oe_o}, 32'h0000_00FF);
      chk({24'h0, port_d_pin_o}, 32'h0000_005A);
      wr(6'h08, 8'h0F, rs);
      repeat (2) @(posedge clk_i);
      chk({24'h0, port_d_pin_oe_o}, 32'h0000_00F0);
      rdr(6'h00, rd, rs);
      chk(rd, 32'h0000_0053);
      $display("test pin direction done");
      reset_n_i <= 1'b0;
      repeat (6) @(posedge clk_i);
      reset_n_i <= 1'b1;
      rdr(6'h08, rd, rs);
      chk(rd, 32'h0000_00FF);
      rdr(6'h04, rd, rs);
      chk(rd, 32'h0000_005A);
      $display("test second reset done");
      wr(6'h14, 8'h00, rs);
      wr(6'h18, 8'h10, rs);
      slave_data_out_i <= 8'h96;
      slave_data_drive_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      chk({port_d_ttl_sense_o, port_e_ttl_sense_o}, 16'hFF07);
      chk({port_d_pin_oe_o, port_d_pin_o}, 16'hFF96);
      chk({port_e_pin_oe_o, port_e_pin_o[7:3]}, {8'hF8, 5'h07});
      chk({read_strobe_pin_o, store_strobe_pin_o, chip_select_pin_o}, 3'b101);
      chk({24'h0, slave_data_in_o}, 32'h0000_0096);
      wr(6'h18, 8'h00, rs);
      repeat (2) @(posedge clk_i);
      chk({port_d_ttl_sense_o, port_e_ttl_sense_o}, 16'h0000);
      $display("test slave mode done");
      wr(6'h14, 8'hFF, rs);
      capture_compare_unit2_oe_i <= 1'b1;
      capture_compare_unit2_out_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      chk({port_e_pin_oe_o, port_e_pin_o[7], capture_compare_unit2_in_o}, 10'b1000_0000_11);
      capture_compare_unit2_oe_i <= 1'b0;
      ext_e_val <= 8'h05;
      repeat (3) @(posedge clk_i);
      chk({port_e_pin_oe_o, capture_compare_unit2_in_o}, 9'h000);
      $display("test shared pin done");
      input_buffer_full_i <= 1'b1;
      output_buffer_full_i <= 1'b1;
      wr(6'h1C, 8'h07, rs);
      wr(6'h20, 8'h00, rs);
      @(posedge clk_i);
      input_overflow_set_i <= 1'b1;
      @(posedge clk_i);
      input_overflow_set_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      chk({31'h0, irq_o}, 32'h0);
      rdr(6'h18, rd, rs);
      chk(rd, 32'h0000_00E0);
      wr(6'h20, 8'h04, rs);
      @(posedge clk_i);
      chk({31'h0, irq_o}, 32'h1);
      wr(6'h1C, 8'h04, rs);
      @(posedge clk_i);
      chk({31'h0, irq_o}, 32'h0);
      $display("test flags and interrupt done");
      tally_and_finish();
   end
endmodule : dpio_top_bench
